// [hdl/rceib_top.sv]
`timescale 1ns/100ps
`include "rceib_params.svh"

module rceib_top #(
	parameter int CELL_WORDS = `RCEIB_CELL_WORDS
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_rd,
	input wire logic i_wr,
	output logic [7:0] o_rd_data,
	output logic o_int_n,
	input wire logic i_ext_valid,
	input wire logic [`RCEIB_WORD_W-1:0] i_ext_word,
	input wire logic i_hec_err,
	input wire logic i_parity_err,
	output logic o_ins_valid,
	output logic o_ins_sop,
	output logic [`RCEIB_WORD_W-1:0] o_ins_word,
	input wire logic i_ins_ready
);
	localparam logic [`RCEIB_PTR_W-1:0] LAST = (`RCEIB_PTR_W)'(CELL_WORDS - 1);
	localparam logic [`RCEIB_PTR_W-1:0] ZERO = '0;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
		hit = (a == ref_a);
	endfunction

	function automatic logic [`RCEIB_PTR_W-1:0] bump(input logic [`RCEIB_PTR_W-1:0] p);
		bump = (p == LAST) ? ZERO : p + 1'b1;
	endfunction

	// Register file state
	logic [`RCEIB_IRQ_BITS-1:0] irq_stat_reg, irq_stat_next;
	logic [`RCEIB_IRQ_BITS-1:0] irq_en_reg, irq_en_next;
	logic ext_rst_n_reg, ext_rst_n_next;
	logic ins_rst_n_reg, ins_rst_n_next;
	logic [23:0] stage_reg, stage_next;
	logic [7:0] rd_data_reg, rd_data_next;

	// Extraction side state
	rceib_pkg::rceib_ext_state_t ext_state_reg, ext_state_next;
	logic [`RCEIB_PTR_W-1:0] ext_wr_ptr_reg, ext_wr_ptr_next;
	logic [`RCEIB_PTR_W-1:0] ext_rd_ptr_reg, ext_rd_ptr_next;
	logic [`RCEIB_WORD_W-1:0] ext_rd_word;

	// Insertion side state
	rceib_pkg::rceib_ins_state_t ins_state_reg, ins_state_next;
	logic [`RCEIB_PTR_W-1:0] ins_wr_ptr_reg, ins_wr_ptr_next;
	logic [`RCEIB_PTR_W-1:0] ins_rd_ptr_reg, ins_rd_ptr_next;
	logic [`RCEIB_WORD_W-1:0] ins_rd_word;
	logic [`RCEIB_WORD_W-1:0] ins_word_reg, ins_word_next;
	logic ins_valid_reg, ins_valid_next;
	logic ins_sop_reg, ins_sop_next;

	logic rd_lsb, wr_lsb, wr_ctrl, rd_stat;
	logic ext_store, ins_store, ext_done, ins_done, ext_ovf, ins_ovf;
	logic [`RCEIB_IRQ_BITS-1:0] irq_set;
	logic ext_hold, ins_room;

	assign ext_hold = (ext_state_reg == rceib_pkg::RCEIB_EXT_HOLD);
	assign ins_room = (ins_state_reg == rceib_pkg::RCEIB_INS_FILL);
	assign rd_lsb = i_rd && hit(i_addr, `RCEIB_ADDR_BYTE_LSB);
	assign wr_lsb = i_wr && hit(i_addr, `RCEIB_ADDR_BYTE_LSB);
	assign wr_ctrl = i_wr && hit(i_addr, `RCEIB_ADDR_MEM_CTRL);
	assign rd_stat = i_rd && hit(i_addr, `RCEIB_ADDR_IRQ_STAT);

	// Extraction buffer accepts words only while filling (no cell held) and not flushed
	assign ext_store = i_ext_valid && !ext_hold && ext_rst_n_reg;
	assign ext_ovf = i_ext_valid && ext_hold && ext_rst_n_reg;
	assign ext_done = ext_store && (ext_wr_ptr_reg == LAST);
	// Insertion word is committed by the lsb byte write
	assign ins_store = wr_lsb && ins_room && ins_rst_n_reg;
	assign ins_ovf = wr_lsb && !ins_room && ins_rst_n_reg;
	assign ins_done = ins_valid_reg && i_ins_ready && (ins_rd_ptr_reg == LAST);

	always_comb begin
		irq_set = '0;
		irq_set[`RCEIB_IRQ_EXTRACTED] = ext_done;
		irq_set[`RCEIB_IRQ_INSERTED] = ins_done;
		irq_set[`RCEIB_IRQ_EXT_OVF] = ext_ovf;
		irq_set[`RCEIB_IRQ_INS_OVF] = ins_ovf;
		irq_set[`RCEIB_IRQ_HEC] = i_hec_err;
		irq_set[`RCEIB_IRQ_PARITY] = i_parity_err;
	end

	rceib_cell_mem #(
		.WIDTH(`RCEIB_WORD_W),
		.DEPTH(CELL_WORDS),
		.AW(`RCEIB_PTR_W)
	) u_ext_mem (
		.i_clock(i_clock),
		.i_wr_en(ext_store),
		.i_wr_addr(ext_wr_ptr_reg),
		.i_wr_word(i_ext_word),
		.i_rd_addr(ext_rd_ptr_reg),
		.o_rd_word(ext_rd_word)
	);

	rceib_cell_mem #(
		.WIDTH(`RCEIB_WORD_W),
		.DEPTH(CELL_WORDS),
		.AW(`RCEIB_PTR_W)
	) u_ins_mem (
		.i_clock(i_clock),
		.i_wr_en(ins_store),
		.i_wr_addr(ins_wr_ptr_reg),
		.i_wr_word({stage_reg, i_wr_data}),
		.i_rd_addr(ins_rd_ptr_next),
		.o_rd_word(ins_rd_word)
	);

	// Register file
	always_comb begin
		irq_en_next = irq_en_reg;
		ext_rst_n_next = ext_rst_n_reg;
		ins_rst_n_next = ins_rst_n_reg;
		stage_next = stage_reg;
		rd_data_next = rd_data_reg;
		// Set wins over the clear so an event in the read cycle survives
		irq_stat_next = (rd_stat ? '0 : irq_stat_reg) | irq_set;
		if (i_wr) begin
			case (i_addr)
				`RCEIB_ADDR_IRQ_EN: begin
					irq_en_next = i_wr_data[`RCEIB_IRQ_BITS-1:0];
				end
				`RCEIB_ADDR_MEM_CTRL: begin
					ext_rst_n_next = i_wr_data[`RCEIB_CTL_EXT_RST_N];
					ins_rst_n_next = i_wr_data[`RCEIB_CTL_INS_RST_N];
				end
				`RCEIB_ADDR_BYTE_MSB: stage_next[23:16] = i_wr_data;
				`RCEIB_ADDR_BYTE_UMID: stage_next[15:8] = i_wr_data;
				`RCEIB_ADDR_BYTE_LMID: stage_next[7:0] = i_wr_data;
				default: stage_next = stage_reg;
			endcase
		end
		if (i_rd) begin
			case (i_addr)
				`RCEIB_ADDR_IRQ_STAT: rd_data_next = {2'b00, irq_stat_reg};
				`RCEIB_ADDR_IRQ_EN: rd_data_next = {2'b00, irq_en_reg};
				`RCEIB_ADDR_MEM_CTRL: begin
					rd_data_next = '0;
					rd_data_next[`RCEIB_CTL_EXT_RST_N] = ext_rst_n_reg;
					rd_data_next[`RCEIB_CTL_CELL_AVAILABLE_FLAG] = ext_hold;
					rd_data_next[`RCEIB_CTL_INS_RST_N] = ins_rst_n_reg;
					rd_data_next[`RCEIB_CTL_INS_ROOM] = ins_room;
				end
				`RCEIB_ADDR_BYTE_MSB: rd_data_next = ext_rd_word[31:24];
				`RCEIB_ADDR_BYTE_UMID: rd_data_next = ext_rd_word[23:16];
				`RCEIB_ADDR_BYTE_LMID: rd_data_next = ext_rd_word[15:8];
				`RCEIB_ADDR_BYTE_LSB: rd_data_next = ext_rd_word[7:0];
				default: rd_data_next = '0;
			endcase
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			irq_stat_reg <= `RCEIB_IRQ_STAT_RST;
			irq_en_reg <= `RCEIB_IRQ_EN_RST;
			ext_rst_n_reg <= 1'b1;
			ins_rst_n_reg <= 1'b1;
			stage_reg <= '0;
			rd_data_reg <= '0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			irq_en_reg <= irq_en_next;
			ext_rst_n_reg <= ext_rst_n_next;
			ins_rst_n_reg <= ins_rst_n_next;
			stage_reg <= stage_next;
			rd_data_reg <= rd_data_next;
		end
	end

	// Extraction buffer: one cell, 14 words in from the filter, bytes out to the host
	always_comb begin
		ext_state_next = ext_state_reg;
		ext_wr_ptr_next = ext_wr_ptr_reg;
		ext_rd_ptr_next = ext_rd_ptr_reg;
		case (ext_state_reg)
			rceib_pkg::RCEIB_EXT_FILL: begin
				if (ext_store) begin
					ext_wr_ptr_next = bump(ext_wr_ptr_reg);
				end
				if (ext_done) begin
					ext_state_next = rceib_pkg::RCEIB_EXT_HOLD;
				end
			end
			rceib_pkg::RCEIB_EXT_HOLD: begin
				// Upper byte reads leave the pointer alone so one word stays coherent
				if (rd_lsb) begin
					ext_rd_ptr_next = bump(ext_rd_ptr_reg);
					if (ext_rd_ptr_reg == LAST) begin
						ext_state_next = rceib_pkg::RCEIB_EXT_FILL;
					end
				end
			end
			default: ext_state_next = rceib_pkg::RCEIB_EXT_FILL;
		endcase
		if (!ext_rst_n_reg) begin
			ext_state_next = rceib_pkg::RCEIB_EXT_FILL;
			ext_wr_ptr_next = ZERO;
			ext_rd_ptr_next = ZERO;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			ext_state_reg <= rceib_pkg::RCEIB_EXT_FILL;
			ext_wr_ptr_reg <= ZERO;
			ext_rd_ptr_reg <= ZERO;
		end else begin
			ext_state_reg <= ext_state_next;
			ext_wr_ptr_reg <= ext_wr_ptr_next;
			ext_rd_ptr_reg <= ext_rd_ptr_next;
		end
	end

	// Insertion buffer: 14 host words, then streamed to the receive cell FIFO
	always_comb begin
		ins_state_next = ins_state_reg;
		ins_wr_ptr_next = ins_wr_ptr_reg;
		ins_rd_ptr_next = ins_rd_ptr_reg;
		ins_word_next = ins_word_reg;
		ins_valid_next = ins_valid_reg;
		ins_sop_next = ins_sop_reg;
		case (ins_state_reg)
			rceib_pkg::RCEIB_INS_FILL: begin
				// Start-of-cell write discards a partly written cell
				if (wr_ctrl && i_wr_data[`RCEIB_CTL_INS_SOC]) begin
					ins_wr_ptr_next = ZERO;
				end
				if (ins_store) begin
					ins_wr_ptr_next = bump(ins_wr_ptr_reg);
					if (ins_wr_ptr_reg == LAST) begin
						// Word 0 is already in memory; present it right away
						ins_state_next = rceib_pkg::RCEIB_INS_SEND;
						ins_valid_next = 1'b1;
						ins_sop_next = 1'b1;
						ins_word_next = ins_rd_word;
					end
				end
			end
			rceib_pkg::RCEIB_INS_SEND: begin
				if (ins_valid_reg && i_ins_ready) begin
					ins_rd_ptr_next = bump(ins_rd_ptr_reg);
					ins_sop_next = 1'b0;
					if (ins_rd_ptr_reg == LAST) begin
						ins_state_next = rceib_pkg::RCEIB_INS_FILL;
						ins_valid_next = 1'b0;
					end else begin
						ins_word_next = ins_rd_word;
					end
				end
			end
			default: ins_state_next = rceib_pkg::RCEIB_INS_FILL;
		endcase
		if (!ins_rst_n_reg) begin
			ins_state_next = rceib_pkg::RCEIB_INS_FILL;
			ins_wr_ptr_next = ZERO;
			ins_rd_ptr_next = ZERO;
			ins_valid_next = 1'b0;
			ins_sop_next = 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			ins_state_reg <= rceib_pkg::RCEIB_INS_FILL;
			ins_wr_ptr_reg <= ZERO;
			ins_rd_ptr_reg <= ZERO;
			ins_word_reg <= '0;
			ins_valid_reg <= 1'b0;
			ins_sop_reg <= 1'b0;
		end else begin
			ins_state_reg <= ins_state_next;
			ins_wr_ptr_reg <= ins_wr_ptr_next;
			ins_rd_ptr_reg <= ins_rd_ptr_next;
			ins_word_reg <= ins_word_next;
			ins_valid_reg <= ins_valid_next;
			ins_sop_reg <= ins_sop_next;
		end
	end

	assign o_rd_data = rd_data_reg;
	assign o_int_n = ~|(irq_stat_reg & irq_en_reg);
	assign o_ins_valid = ins_valid_reg;
	assign o_ins_sop = ins_sop_reg;
	assign o_ins_word = ins_word_reg;
endmodule

// [inc/rceib_params.svh]
`ifndef RCEIB_PARAMS_SVH
`define RCEIB_PARAMS_SVH

// Register addresses, low address byte of the processor port
`define RCEIB_ADDR_IRQ_STAT 8'h0b
`define RCEIB_ADDR_IRQ_EN 8'h0f
`define RCEIB_ADDR_MEM_CTRL 8'h13
`define RCEIB_ADDR_BYTE_MSB 8'h14
`define RCEIB_ADDR_BYTE_UMID 8'h15
`define RCEIB_ADDR_BYTE_LMID 8'h16
`define RCEIB_ADDR_BYTE_LSB 8'h17

// Interrupt status and enable bit positions
`define RCEIB_IRQ_EXTRACTED 5
`define RCEIB_IRQ_INSERTED 4
`define RCEIB_IRQ_EXT_OVF 3
`define RCEIB_IRQ_INS_OVF 2
`define RCEIB_IRQ_HEC 1
`define RCEIB_IRQ_PARITY 0
`define RCEIB_IRQ_BITS 6

// Memory control bit positions
`define RCEIB_CTL_EXT_RST_N 4
`define RCEIB_CTL_CELL_AVAILABLE_FLAG 3
`define RCEIB_CTL_INS_RST_N 2
`define RCEIB_CTL_INS_ROOM 1
`define RCEIB_CTL_INS_SOC 0

// Reset values
`define RCEIB_IRQ_EN_RST 6'h20
`define RCEIB_IRQ_STAT_RST 6'h00

// Cell geometry: 56 bytes as 14 words of 32 bits
`define RCEIB_CELL_WORDS 14
`define RCEIB_PTR_W 4
`define RCEIB_WORD_W 32

`endif

// [inc/rceib_pkg.sv]
package rceib_pkg;

	typedef enum logic [1:0] {
		RCEIB_EXT_FILL = 2'b01,
		RCEIB_EXT_HOLD = 2'b10
	} rceib_ext_state_t;

	typedef enum logic [1:0] {
		RCEIB_INS_FILL = 2'b01,
		RCEIB_INS_SEND = 2'b10
	} rceib_ins_state_t;

endpackage

// [hdl/rceib_cell_mem.sv]
`timescale 1ns/100ps
`include "rceib_params.svh"

module rceib_cell_mem #(
	parameter int WIDTH = `RCEIB_WORD_W,
	parameter int DEPTH = `RCEIB_CELL_WORDS,
	parameter int AW = `RCEIB_PTR_W
) (
	input wire logic i_clock,
	input wire logic i_wr_en,
	input wire logic [AW-1:0] i_wr_addr,
	input wire logic [WIDTH-1:0] i_wr_word,
	input wire logic [AW-1:0] i_rd_addr,
	output logic [WIDTH-1:0] o_rd_word
);
	// Contents need no reset; pointers in the owner decide what is valid
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge i_clock) begin
		if (i_wr_en) begin
			mem[i_wr_addr] <= i_wr_word;
		end
	end

	assign o_rd_word = mem[i_rd_addr];
endmodule

// [tb/rceib_fifo_model.sv]
`timescale 1ns/100ps
module rceib_fifo_model (
	input wire logic i_clock,
	input wire logic i_stall,
	input wire logic i_valid,
	input wire logic i_sop,
	input wire logic [31:0] i_word,
	output logic o_ready
);
	logic [31:0] words [0:15];
	logic sops [0:15];
	int count = 0;
	initial begin
		o_ready = 1'b0;
	end
	// Ready every other cycle, so each word must be held across a stall
	// Ready moves on the edge so the stall input is never sampled in a race
	always @(posedge i_clock) begin
		if (i_valid && o_ready && count < 16) begin
			words[count] = i_word;
			sops[count] = i_sop;
			count++;
		end
		o_ready <= !i_stall && !o_ready;
	end
endmodule

// [tb/rceib_assertions.sv]
`timescale 1ns/100ps
module rceib_assertions #(
	parameter int CELL_WORDS = 14
) (
	input wire logic i_clock,
	input wire logic i_nrst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [7:0] o_rd_data,
	input wire logic o_int_n,
	input wire logic i_ext_valid,
	input wire logic [31:0] i_ext_word,
	input wire logic i_hec_err,
	input wire logic i_parity_err,
	input wire logic o_ins_valid,
	input wire logic o_ins_sop,
	input wire logic [31:0] o_ins_word,
	input wire logic i_ins_ready
);
	logic [4:0] seen_reg;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_nrst);
	// Words of the current cell taken by the FIFO
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			seen_reg <= 5'h00;
		end else if (o_ins_valid && i_ins_ready) begin
			seen_reg <= o_ins_sop ? 5'h01 : seen_reg + 5'h01;
		end
	end
	a_stat_top_zero: assert property (
		i_rd && i_addr == 8'h0b |=> o_rd_data[7:6] == 2'h0) else $error("status top bits");
	a_int_release: assert property (
		$rose(o_int_n) |-> $past(i_rd && i_addr == 8'h0b || i_wr && i_addr == 8'h0f))
		else $error("interrupt released without cause");
	a_rd_hold: assert property (
		!i_rd |=> $stable(o_rd_data)) else $error("read data moved");
	a_room_low: assert property (
		i_rd && i_addr == 8'h13 && o_ins_valid |=> !o_rd_data[1]) else $error("room while sending");
	a_ins_hold: assert property (
		o_ins_valid && !i_ins_ready |=> o_ins_valid && $stable(o_ins_word) && $stable(o_ins_sop))
		else $error("insertion word dropped");
	a_sop_first: assert property (
		$rose(o_ins_valid) |-> o_ins_sop) else $error("cell starts without sop");
	a_sop_once: assert property (
		o_ins_valid && o_ins_sop && i_ins_ready |=> !o_ins_sop) else $error("sop repeated");
	a_cell_words: assert property (
		$fell(o_ins_valid) |-> seen_reg == CELL_WORDS) else $error("cell length wrong");
endmodule
bind rceib_top rceib_assertions #(.CELL_WORDS(CELL_WORDS)) i_rceib_assertions (
	.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wr_data(i_wr_data),
	.i_rd(i_rd), .i_wr(i_wr), .o_rd_data(o_rd_data), .o_int_n(o_int_n),
	.i_ext_valid(i_ext_valid), .i_ext_word(i_ext_word), .i_hec_err(i_hec_err),
	.i_parity_err(i_parity_err), .o_ins_valid(o_ins_valid), .o_ins_sop(o_ins_sop),
	.o_ins_word(o_ins_word), .i_ins_ready(i_ins_ready));

// [tb/tb.sv]
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
	logic i_clock = 1'b0;
	logic i_nrst = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wr_data = 8'h00;
	logic i_rd = 1'b0;
	logic i_wr = 1'b0;
	logic i_ext_valid = 1'b0;
	logic [31:0] i_ext_word = 32'h0;
	logic i_hec_err = 1'b0;
	logic i_parity_err = 1'b0;
	logic stall = 1'b1;
	logic i_ins_ready;
	logic [7:0] o_rd_data;
	logic o_int_n;
	logic o_ins_valid;
	logic o_ins_sop;
	logic [31:0] o_ins_word;
	logic [7:0] d;
	logic [31:0] w;
	int i;
	int err_count = 0;
	int comparisons = 0;
	int cyc = 0;
	rceib_top i_rceib_top (.i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr),
		.i_wr_data(i_wr_data), .i_rd(i_rd), .i_wr(i_wr), .o_rd_data(o_rd_data),
		.o_int_n(o_int_n), .i_ext_valid(i_ext_valid), .i_ext_word(i_ext_word),
		.i_hec_err(i_hec_err), .i_parity_err(i_parity_err), .o_ins_valid(o_ins_valid),
		.o_ins_sop(o_ins_sop), .o_ins_word(o_ins_word), .i_ins_ready(i_ins_ready));
	rceib_fifo_model i_rceib_fifo_model (.i_clock(i_clock), .i_stall(stall),
		.i_valid(o_ins_valid), .i_sop(o_ins_sop), .i_word(o_ins_word), .o_ready(i_ins_ready));
	initial begin
		forever #10 i_clock = ~i_clock;
	end
	task automatic complete_run();
		$display("Mismatches %0d, comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Whole run is a few hundred cycles
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			complete_run();
		end
	end
	function automatic logic [31:0] cw(input logic [7:0] k);
		return {k, k + 8'h01, k + 8'h02, k + 8'h03};
	endfunction
	// One access, then an idle cycle so strobes never toggle twice in a step
	task automatic op(input logic wr, input logic [7:0] a, input logic [7:0] v);
		i_addr = a;
		i_wr_data = v;
		i_rd = !wr;
		i_wr = wr;
		@(posedge i_clock);
		#1;
		i_rd = 1'b0;
		i_wr = 1'b0;
		d = o_rd_data;
		@(posedge i_clock);
		#1;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		op(1'b0, a, 8'h00);
		`CHK(d, e)
	endtask
	initial begin
		repeat (8) @(posedge i_clock);
		#1 i_nrst = 1'b1;
		@(posedge i_clock);
		#1;
		`CHK(o_int_n, 1'b1)
		rchk(8'h0f, 8'h20);
		rchk(8'h13, 8'h16);
		rchk(8'h00, 8'h00);
		op(1'b1, 8'h13, 8'h12);
		op(1'b1, 8'h13, 8'h16);
		rchk(8'h13, 8'h16);
		// Fifteenth word arrives while the cell is held and must be dropped
		for (i = 0; i < 15; i++) begin
			i_ext_valid = 1'b1;
			i_ext_word = cw(8'(4 * i));
			@(posedge i_clock);
			#1;
		end
		i_ext_valid = 1'b0;
		`CHK(o_int_n, 1'b0)
		rchk(8'h0b, 8'h28);
		rchk(8'h0b, 8'h00);
		`CHK(o_int_n, 1'b1)
		rchk(8'h13, 8'h1e);
		for (i = 0; i < 14; i++) begin
			w = cw(8'(4 * i));
			rchk(8'h14, w[31:24]);
			rchk(8'h14, w[31:24]);
			rchk(8'h15, w[23:16]);
			rchk(8'h16, w[15:8]);
			rchk(8'h17, w[7:0]);
		end
		rchk(8'h13, 8'h16);
		i_hec_err = 1'b1;
		i_parity_err = 1'b1;
		@(posedge i_clock);
		#1;
		i_hec_err = 1'b0;
		i_parity_err = 1'b0;
		rchk(8'h0b, 8'h03);
		op(1'b1, 8'h0f, 8'h30);
		rchk(8'h0f, 8'h30);
		// A stray word before the flush must not shift the next cell
		op(1'b1, 8'h17, 8'hee);
		op(1'b1, 8'h13, 8'h12);
		op(1'b1, 8'h13, 8'h16);
		// FIFO stalled: the cell must wait whole in the insertion buffer
		for (i = 0; i < 14; i++) begin
			w = cw(8'(100 + 4 * i));
			op(1'b1, 8'h14, w[31:24]);
			op(1'b1, 8'h15, w[23:16]);
			op(1'b1, 8'h16, w[15:8]);
			op(1'b1, 8'h17, w[7:0]);
		end
		rchk(8'h13, 8'h14);
		op(1'b1, 8'h17, 8'h55);
		stall = 1'b0;
		for (i = 0; i < 100 && i_rceib_fifo_model.count < 14; i++) begin
			@(posedge i_clock);
		end
		#1;
		`CHK(i_rceib_fifo_model.count, 14)
		for (i = 0; i < 14; i++) begin
			`CHK(i_rceib_fifo_model.words[i], cw(8'(100 + 4 * i)))
			`CHK(i_rceib_fifo_model.sops[i], (i == 0))
		end
		`CHK(o_int_n, 1'b0)
		rchk(8'h13, 8'h16);
		rchk(8'h0b, 8'h14);
		`CHK(o_int_n, 1'b1)
		complete_run();
	end
endmodule
